// file: umct_pkg.sv
`default_nettype none
package umct_pkg;

    // register addresses on the byte-wide cpu port
    localparam logic [15:0] UMCT_MODE_ADDR  = 16'hFF70;
    localparam logic [15:0] UMCT_BAUD_ADDR  = 16'hFF71;
    localparam logic [15:0] UMCT_DATA_ADDR  = 16'hFF72;
    localparam logic [15:0] UMCT_ERR_ADDR   = 16'hFF73;
    localparam logic [15:0] UMCT_DIR_ADDR   = 16'hFF21;
    localparam logic [15:0] UMCT_LATCH_ADDR = 16'hFF01;

    // values after reset
    localparam logic [7:0] UMCT_MODE_RESET  = 8'h01;
    localparam logic [7:0] UMCT_BAUD_RESET  = 8'h1F;
    localparam logic [7:0] UMCT_DIR_RESET   = 8'hFF;
    localparam logic [7:0] UMCT_LATCH_RESET = 8'h00;
    localparam logic [7:0] UMCT_ERR_RESET   = 8'h00;

    // base clock prescaler masks: fx/2, fx/8, fx/32
    localparam logic [4:0] UMCT_DIV2_MASK  = 5'h01;
    localparam logic [4:0] UMCT_DIV8_MASK  = 5'h07;
    localparam logic [4:0] UMCT_DIV32_MASK = 5'h1F;

    // character bit indices of the last data bit
    localparam logic [2:0] UMCT_LAST_BIT8 = 3'h7;
    localparam logic [2:0] UMCT_LAST_BIT7 = 3'h6;

    typedef enum logic [1:0] {
        UMCT_TPS_TIMER = 2'h0,
        UMCT_TPS_DIV2  = 2'h1,
        UMCT_TPS_DIV8  = 2'h2,
        UMCT_TPS_DIV32 = 2'h3
    } umct_tps_e;

    typedef enum logic [1:0] {
        UMCT_PAR_NONE = 2'h0,
        UMCT_PAR_ZERO = 2'h1,
        UMCT_PAR_ODD  = 2'h2,
        UMCT_PAR_EVEN = 2'h3
    } umct_parity_e;

    typedef enum logic [4:0] {
        UMCT_S_IDLE   = 5'h01,
        UMCT_S_START  = 5'h02,
        UMCT_S_DATA   = 5'h04,
        UMCT_S_PARITY = 5'h08,
        UMCT_S_STOP   = 5'h10
    } umct_state_e;

    typedef struct packed {
        logic         uart_power_on;
        logic         transmit_enable_bit;
        logic         receive_enable_bit;
        umct_parity_e parity_select;
        logic         char_length_select;
        logic         stop_length_select;
        logic         fixed_one;
    } umct_mode_s;

    typedef struct packed {
        umct_tps_e    base_select;
        logic         unused;
        logic [4:0]   baud_divisor_field;
    } umct_baud_s;

    typedef struct packed {
        logic [4:0]   zero;
        logic         parity_err;
        logic         framing_err;
        logic         overrun_err;
    } umct_err_s;

endpackage
`default_nettype wire

// file: umct_top.sv
`timescale 1ns/1ps
`default_nettype none
module umct_top
    import umct_pkg::*;
(
    input  wire logic        MCLK_I,
    input  wire logic        RESETN_I,
    input  wire logic [15:0] ADDR_I,
    input  wire logic [7:0]  WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    input  wire logic        TIMER_TICK_I,
    input  wire logic        SERIAL_INPUT_PIN_I,
    output logic [7:0]       RDATA_O,
    output logic             SERIAL_OUTPUT_PIN_O,
    output logic             SERIAL_OUTPUT_OE_O,
    output logic             TRANSMIT_DONE_O,
    output logic             RECEIVE_DONE_O
);

    umct_mode_s   mode;
    umct_baud_s   baud;
    logic [7:0]   port1_direction;
    logic [7:0]   port1_latch;
    umct_err_s    err;
    logic [7:0]   rx_buffer;
    logic         rx_full;
    logic [4:0]   presc;
    umct_state_e  tx_state;
    logic [5:0]   tx_cnt;
    logic [2:0]   tx_bit;
    logic [7:0]   tx_shift;
    logic [7:0]   tx_hold;
    logic         tx_done;
    logic         smp_a;
    logic         smp_b;
    logic         filt;
    logic         filt_last;
    umct_state_e  rx_state;
    logic [5:0]   rx_cnt;
    logic [2:0]   rx_bit;
    logic [7:0]   rx_shift;
    logic         rx_ones;
    logic         rx_done;

    // cpu port decode
    wire wr_mode  = WR_I && (ADDR_I == UMCT_MODE_ADDR);
    wire wr_baud  = WR_I && (ADDR_I == UMCT_BAUD_ADDR);
    wire wr_data  = WR_I && (ADDR_I == UMCT_DATA_ADDR);
    wire wr_dir   = WR_I && (ADDR_I == UMCT_DIR_ADDR);
    wire wr_latch = WR_I && (ADDR_I == UMCT_LATCH_ADDR);
    wire rd_data  = RD_I && (ADDR_I == UMCT_DATA_ADDR);
    wire rd_err   = RD_I && (ADDR_I == UMCT_ERR_ADDR);

    wire [7:0] rd_value =
        (ADDR_I == UMCT_MODE_ADDR)  ? mode            :
        (ADDR_I == UMCT_BAUD_ADDR)  ? baud            :
        (ADDR_I == UMCT_DATA_ADDR)  ? rx_buffer       :
        (ADDR_I == UMCT_ERR_ADDR)   ? err             :
        (ADDR_I == UMCT_DIR_ADDR)   ? port1_direction :
        (ADDR_I == UMCT_LATCH_ADDR) ? port1_latch     : 8'h00;

    // serial logic is held in reset while power is off
    wire serial_rst_n = RESETN_I & mode.uart_power_on;

    // base clock selection, stuck low while unpowered
    wire [4:0] presc_mask =
        (baud.base_select == UMCT_TPS_DIV2) ? UMCT_DIV2_MASK :
        (baud.base_select == UMCT_TPS_DIV8) ? UMCT_DIV8_MASK : UMCT_DIV32_MASK;
    wire base_sel_tick = (baud.base_select == UMCT_TPS_TIMER) ? TIMER_TICK_I
                                                              : ((presc & presc_mask) == presc_mask);
    wire base_tick = mode.uart_power_on && base_sel_tick;

    // bit time is two divisor counts of the base clock
    wire [5:0] bit_last  = {baud.baud_divisor_field, 1'b0} - 6'h01;
    wire [5:0] half_last = {1'b0, baud.baud_divisor_field} - 6'h01;

    // transmit parity and line level
    wire [7:0] tx_char   = mode.char_length_select ? tx_hold : {1'b0, tx_hold[6:0]};
    wire       tx_par    = (mode.parity_select == UMCT_PAR_EVEN) ? (^tx_char) :
                           (mode.parity_select == UMCT_PAR_ODD)  ? ~(^tx_char) :
                           1'b0;
    wire [2:0] last_bit  = mode.char_length_select ? UMCT_LAST_BIT8 : UMCT_LAST_BIT7;
    wire       tx_line   = (tx_state == UMCT_S_START)  ? 1'b0 :
                           (tx_state == UMCT_S_DATA)   ? tx_shift[0] :
                           (tx_state == UMCT_S_PARITY) ? tx_par : 1'b1;
    wire       tx_bit_end = base_tick && (tx_cnt == bit_last);
    wire       tx_idle    = (tx_state == UMCT_S_IDLE);

    // receive path, forced high without power
    wire rx_in       = mode.uart_power_on ? SERIAL_INPUT_PIN_I : 1'b1;
    wire rx_bit_end  = base_tick && (rx_cnt == bit_last);
    wire rx_finish   = (rx_state == UMCT_S_STOP) && rx_bit_end;
    wire par_bad     = (mode.parity_select == UMCT_PAR_EVEN) ? rx_ones :
                       (mode.parity_select == UMCT_PAR_ODD)  ? ~rx_ones :
                       1'b0;
    wire pe_set      = rx_finish && par_bad;
    wire fe_set      = rx_finish && !filt;
    wire ov_set      = rx_finish && rx_full;
    wire [7:0] rx_char = mode.char_length_select ? rx_shift : {1'b0, rx_shift[7:1]};

    // software registers
    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            mode            <= umct_mode_s'(UMCT_MODE_RESET);
            baud            <= umct_baud_s'(UMCT_BAUD_RESET);
            port1_direction <= UMCT_DIR_RESET;
            port1_latch     <= UMCT_LATCH_RESET;
        end else begin
            if (wr_mode)
                mode <= umct_mode_s'(WDATA_I);
            if (wr_baud)
                baud <= umct_baud_s'({WDATA_I[7:6], 1'b0, WDATA_I[4:0]});
            if (wr_dir)
                port1_direction <= WDATA_I;
            if (wr_latch)
                port1_latch <= WDATA_I;
        end
    end

    // registered read data and pins
    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            RDATA_O             <= 8'h00;
            SERIAL_OUTPUT_PIN_O <= 1'b0;
            SERIAL_OUTPUT_OE_O  <= 1'b0;
            TRANSMIT_DONE_O     <= 1'b0;
            RECEIVE_DONE_O      <= 1'b0;
        end else begin
            RDATA_O             <= RD_I ? rd_value : 8'h00;
            SERIAL_OUTPUT_PIN_O <= mode.uart_power_on ? tx_line : port1_latch[0];
            SERIAL_OUTPUT_OE_O  <= ~port1_direction[0];
            TRANSMIT_DONE_O     <= tx_done;
            RECEIVE_DONE_O      <= rx_done;
        end
    end

    // prescaler
    always_ff @(posedge MCLK_I or negedge serial_rst_n) begin
        if (!serial_rst_n)
            presc <= 5'h00;
        else
            presc <= presc + 5'h01;
    end

    // transmitter
    always_ff @(posedge MCLK_I or negedge serial_rst_n) begin
        if (!serial_rst_n) begin
            tx_state <= UMCT_S_IDLE;
            tx_cnt   <= 6'h00;
            tx_bit   <= 3'h0;
            tx_shift <= 8'h00;
            tx_hold  <= 8'h00;
            tx_done  <= 1'b0;
        end else if (!mode.transmit_enable_bit) begin
            tx_state <= UMCT_S_IDLE;
            tx_cnt   <= 6'h00;
            tx_bit   <= 3'h0;
            tx_done  <= 1'b0;
        end else begin
            tx_done <= 1'b0;
            if (tx_idle) begin
                if (wr_data) begin
                    tx_shift <= WDATA_I;
                    tx_hold  <= WDATA_I;
                    tx_cnt   <= 6'h00;
                    tx_bit   <= 3'h0;
                    tx_state <= UMCT_S_START;
                end
            end else if (base_tick) begin
                tx_cnt <= tx_bit_end ? 6'h00 : tx_cnt + 6'h01;
                if (tx_bit_end) begin
                    case (tx_state)
                        UMCT_S_START: begin
                            tx_state <= UMCT_S_DATA;
                        end
                        UMCT_S_DATA: begin
                            tx_shift <= {1'b0, tx_shift[7:1]};
                            tx_bit   <= (tx_bit == last_bit) ? 3'h0 : tx_bit + 3'h1;
                            if (tx_bit == last_bit)
                                tx_state <= (mode.parity_select == UMCT_PAR_NONE) ?
                                            UMCT_S_STOP : UMCT_S_PARITY;
                        end
                        UMCT_S_PARITY: begin
                            tx_state <= UMCT_S_STOP;
                        end
                        UMCT_S_STOP: begin
                            if (mode.stop_length_select && (tx_bit == 3'h0)) begin
                                tx_bit <= 3'h1;
                            end else begin
                                tx_bit   <= 3'h0;
                                tx_state <= UMCT_S_IDLE;
                                tx_done  <= 1'b1;
                            end
                        end
                        default: begin
                            tx_state <= UMCT_S_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    // two-sample match filter on the base clock
    always_ff @(posedge MCLK_I or negedge serial_rst_n) begin
        if (!serial_rst_n) begin
            smp_a     <= 1'b1;
            smp_b     <= 1'b1;
            filt      <= 1'b1;
            filt_last <= 1'b1;
        end else if (base_tick) begin
            smp_a     <= rx_in;
            smp_b     <= smp_a;
            filt_last <= filt;
            if (smp_a == smp_b)
                filt <= smp_b;
        end
    end

    // receiver
    always_ff @(posedge MCLK_I or negedge serial_rst_n) begin
        if (!serial_rst_n) begin
            rx_state <= UMCT_S_IDLE;
            rx_cnt   <= 6'h00;
            rx_bit   <= 3'h0;
            rx_shift <= 8'h00;
            rx_ones  <= 1'b0;
            rx_done  <= 1'b0;
        end else if (!mode.receive_enable_bit) begin
            rx_state <= UMCT_S_IDLE;
            rx_cnt   <= 6'h00;
            rx_bit   <= 3'h0;
            rx_ones  <= 1'b0;
            rx_done  <= 1'b0;
        end else begin
            rx_done <= rx_finish;
            case (rx_state)
                UMCT_S_IDLE: begin
                    rx_cnt <= 6'h00;
                    if (base_tick && filt_last && !filt) begin
                        rx_state <= UMCT_S_START;
                        rx_ones  <= 1'b0;
                        rx_bit   <= 3'h0;
                    end
                end
                UMCT_S_START: begin
                    if (base_tick) begin
                        rx_cnt <= (rx_cnt == half_last) ? 6'h00 : rx_cnt + 6'h01;
                        if (rx_cnt == half_last)
                            rx_state <= filt ? UMCT_S_IDLE : UMCT_S_DATA;
                    end
                end
                default: begin
                    if (base_tick)
                        rx_cnt <= rx_bit_end ? 6'h00 : rx_cnt + 6'h01;
                    if (rx_bit_end) begin
                        if (rx_state == UMCT_S_DATA) begin
                            rx_shift <= {filt, rx_shift[7:1]};
                            rx_ones  <= rx_ones ^ filt;
                            rx_bit   <= rx_bit + 3'h1;
                            if (rx_bit == last_bit)
                                rx_state <= (mode.parity_select == UMCT_PAR_NONE) ?
                                            UMCT_S_STOP : UMCT_S_PARITY;
                        end else if (rx_state == UMCT_S_PARITY) begin
                            rx_ones  <= rx_ones ^ filt;
                            rx_state <= UMCT_S_STOP;
                        end else begin
                            rx_state <= UMCT_S_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // receive buffer and error flags; an error flag set beats a read clear
    always_ff @(posedge MCLK_I or negedge serial_rst_n) begin
        if (!serial_rst_n) begin
            rx_buffer <= 8'h00;
            rx_full   <= 1'b0;
            err       <= umct_err_s'(UMCT_ERR_RESET);
        end else begin
            if (rx_finish && !rx_full)
                rx_buffer <= rx_char;
            rx_full <= (rx_finish && !rx_full) || (rx_full && !rd_data);
            if (!mode.receive_enable_bit) begin
                err <= umct_err_s'(UMCT_ERR_RESET);
            end else begin
                err.parity_err  <= pe_set || (err.parity_err && !rd_err);
                err.framing_err <= fe_set || (err.framing_err && !rd_err);
                err.overrun_err <= ov_set || (err.overrun_err && !rd_err);
            end
        end
    end

    chk_power_off_reset: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        !mode.uart_power_on |-> (tx_state == UMCT_S_IDLE) && (err == 8'h00) && !rx_full)
        else $error("serial logic not reset while power is off");

    chk_txe_off_idle: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        !mode.transmit_enable_bit |=> (tx_state == UMCT_S_IDLE) && !tx_done)
        else $error("transmitter active with transmit disabled");

    chk_rxe_off_clear: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        !mode.receive_enable_bit |=> (rx_state == UMCT_S_IDLE) && (err == 8'h00))
        else $error("receiver or errors not cleared with receive disabled");

    chk_rx_forced_high: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        !mode.uart_power_on |-> rx_in && filt)
        else $error("receive path not high while unpowered");

    chk_stop_mode_port: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        !mode.uart_power_on |=> SERIAL_OUTPUT_PIN_O == $past(port1_latch[0]))
        else $error("output pin not following port latch in stop mode");

    chk_dir_buffer: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        ##1 SERIAL_OUTPUT_OE_O == !$past(port1_direction[0]))
        else $error("output enable does not follow direction bit");

    chk_idle_high: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        (mode.uart_power_on && tx_idle) |=> SERIAL_OUTPUT_PIN_O)
        else $error("powered idle output not high");

    chk_write_starts: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        (wr_data && tx_idle && mode.uart_power_on && mode.transmit_enable_bit)
        |=> (tx_state == UMCT_S_START) ##1 !SERIAL_OUTPUT_PIN_O)
        else $error("data write did not start a frame");

    chk_parity_value: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        (tx_state == UMCT_S_PARITY) |-> (mode.parity_select != UMCT_PAR_NONE) &&
            ((mode.parity_select == UMCT_PAR_ZERO) ? !tx_line :
             (($countones({tx_char, tx_line}) % 2) == (mode.parity_select == UMCT_PAR_ODD))))
        else $error("transmitted parity bit wrong");

    chk_done_after_stop: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
        $rose(tx_done) |-> $past(tx_state == UMCT_S_STOP) && tx_idle ##1 TRANSMIT_DONE_O)
        else $error("done pulse not right after the stop bit");

endmodule // umct_top
`default_nettype wire

// file: umct_dummy_unused_never.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: umct_remote.sv
`timescale 1ns/1ps
`default_nettype none
module umct_remote
    import umct_pkg::*;
#(
    parameter int BIT_CYCLES = 32
) (
    input  wire logic clk_i,
    input  wire logic line_i,
    output logic      line_o
);
    initial line_o = 1'b1;

    // sends start, lsb-first data, optional parity, one stop
    task automatic send_frame(input logic [7:0] d, input int nbits, input bit has_par,
                              input logic par);
        line_o <= 1'b0;
        repeat (BIT_CYCLES) @(posedge clk_i);
        for (int i = 0; i < nbits; i++) begin
            line_o <= d[i];
            repeat (BIT_CYCLES) @(posedge clk_i);
        end
        if (has_par) begin
            line_o <= par;
            repeat (BIT_CYCLES) @(posedge clk_i);
        end
        line_o <= 1'b1;
        repeat (BIT_CYCLES) @(posedge clk_i);
    endtask

    // captures a frame, sampling mid-bit; returns at the middle of the last stop bit
    task automatic get_frame(input int nbits, input bit has_par, input int nstop,
                             output logic [7:0] d, output logic par, output logic stop_ok,
                             output logic [7:0] low_len);
        int w;
        d = 8'h00;
        par = 1'b0;
        stop_ok = 1'b1;
        low_len = 8'h00;
        w = 0;
        while (line_i !== 1'b0 && w < 5000) begin
            @(posedge clk_i);
            w++;
        end
        while (line_i === 1'b0 && low_len < 8'h40) begin
            @(posedge clk_i);
            low_len = low_len + 8'h01;
        end
        repeat (BIT_CYCLES / 2) @(posedge clk_i);
        for (int i = 0; i < nbits; i++) begin
            d[i] = line_i;
            repeat (BIT_CYCLES) @(posedge clk_i);
        end
        if (has_par) begin
            par = line_i;
            repeat (BIT_CYCLES) @(posedge clk_i);
        end
        for (int i = 0; i < nstop; i++) begin
            stop_ok = stop_ok & (line_i === 1'b1);
            if (i < nstop - 1) repeat (BIT_CYCLES) @(posedge clk_i);
        end
    endtask
endmodule // umct_remote
`default_nettype wire

// file: umct_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module umct_top_bench
    import umct_pkg::*;
;
    typedef struct packed {
        logic [1:0] par;
        logic       cl;
        logic       sl;
        logic [7:0] data;
        logic       exp_par;
        logic [7:0] err_flip;
    } umct_row_s;

    // rows: parity, length, stop, data, parity bit sent, error when parity flipped
    localparam umct_row_s ROWS [4] = '{
        '{2'h3, 1'b1, 1'b0, 8'h57, 1'b1, 8'h04},
        '{2'h2, 1'b0, 1'b1, 8'h37, 1'b0, 8'h04},
        '{2'h0, 1'b1, 1'b0, 8'h87, 1'b0, 8'h00},
        '{2'h1, 1'b1, 1'b0, 8'h7F, 1'b0, 8'h00}
    };

    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00;
    logic        wr_s = 1'b0;
    logic        rd_s = 1'b0;
    logic        tick = 1'b0;
    logic [1:0]  tick_cnt = 2'h0;
    logic        rx_line;
    logic [7:0]  rdata;
    logic        pin;
    logic        oe;
    logic        tdone;
    logic        rdone;
    int          fail_count = 0;
    int          check_count = 0;
    int          tx_n = 0;
    int          rx_n = 0;

    always #10 mclk = ~mclk;

    always @(posedge mclk) begin
        tick_cnt <= tick_cnt + 2'h1;
        tick     <= (tick_cnt == 2'h0);
        if (tdone === 1'b1) tx_n <= tx_n + 1;
        if (rdone === 1'b1) rx_n <= rx_n + 1;
    end

    umct_top dut (
        .MCLK_I             (mclk),
        .RESETN_I           (resetn),
        .ADDR_I             (addr),
        .WDATA_I            (wdata),
        .WR_I               (wr_s),
        .RD_I               (rd_s),
        .TIMER_TICK_I       (tick),
        .SERIAL_INPUT_PIN_I (rx_line),
        .RDATA_O            (rdata),
        .SERIAL_OUTPUT_PIN_O(pin),
        .SERIAL_OUTPUT_OE_O (oe),
        .TRANSMIT_DONE_O    (tdone),
        .RECEIVE_DONE_O     (rdone)
    );

    umct_remote #(.BIT_CYCLES(32)) remote (
        .clk_i (mclk),
        .line_i(pin),
        .line_o(rx_line)
    );

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        addr = a;
        wdata = d;
        wr_s = 1'b1;
        @(posedge mclk);
        #1;
        wr_s = 1'b0;
    endtask

    task automatic rdchk(input string name, input logic [15:0] a, input logic [7:0] exp);
        @(posedge mclk);
        #1;
        addr = a;
        rd_s = 1'b1;
        @(posedge mclk);
        #1;
        rd_s = 1'b0;
        check(name, rdata, exp);
    endtask

    task automatic wait_tx(output int n);
        n = 0;
        #1;
        while (tdone !== 1'b1 && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= 100) begin
            fail_count++;
            $display("Error transmit done never seen");
            tally_and_finish();
        end
    endtask

    task automatic count_low(input int n, output logic [7:0] lows);
        lows = 8'h00;
        repeat (n) begin
            @(posedge mclk);
            #1;
            if (pin !== 1'b1) lows = lows + 8'h01;
        end
    endtask

    initial begin
        repeat (100000) @(posedge mclk);
        fail_count++;
        $display("Error run limit reached");
        tally_and_finish();
    end

    initial begin
        umct_row_s   r;
        logic [7:0]  fmt;
        logic [7:0]  d;
        logic [7:0]  len;
        logic [7:0]  lows;
        logic        p;
        logic        sok;
        int          n;
        int          cnt;
        repeat (4) @(posedge mclk);
        #1;
        resetn = 1'b1;
        check("oe after reset", {7'h00, oe}, 8'h00);
        wr(UMCT_BAUD_ADDR, 8'h48);
        wr(UMCT_DIR_ADDR, 8'hFE);
        wr(UMCT_LATCH_ADDR, 8'h01);
        check("oe driving", {7'h00, oe}, 8'h01);
        foreach (ROWS[i]) begin
            r = ROWS[i];
            fmt = {3'b000, r.par, r.cl, r.sl, 1'b1};
            wr(UMCT_MODE_ADDR, fmt);
            wr(UMCT_MODE_ADDR, fmt | 8'h80);
            wr(UMCT_MODE_ADDR, fmt | 8'hE0);
            repeat (8) @(posedge mclk);
            check("idle level", {7'h00, pin}, 8'h01);
            wr(UMCT_DATA_ADDR, r.data);
            remote.get_frame(r.cl ? 8 : 7, r.par != 2'h0, r.sl ? 2 : 1, d, p, sok, len);
            check("tx data", d, r.cl ? r.data : (r.data & 8'h7F));
            check("tx parity", {7'h00, p}, {7'h00, r.exp_par});
            check("tx stop", {7'h00, sok}, 8'h01);
            check("start length", len, 8'h20);
            wait_tx(n);
            check("done delay", {7'h00, (n >= 14 && n <= 20)}, 8'h01);
            for (int f = 0; f < 2; f++) begin
                cnt = rx_n;
                remote.send_frame(r.data, r.cl ? 8 : 7, r.par != 2'h0, r.exp_par ^ f[0]);
                repeat (4) @(posedge mclk);
                check("rx done", 8'(rx_n - cnt), 8'h01);
                rdchk("rx error", UMCT_ERR_ADDR, f ? r.err_flip : 8'h00);
                rdchk("rx data", UMCT_DATA_ADDR, r.data);
            end
            wr(UMCT_MODE_ADDR, fmt | 8'h80);
            wr(UMCT_MODE_ADDR, fmt);
        end
        wr(UMCT_MODE_ADDR, 8'h9D);
        wr(UMCT_MODE_ADDR, 8'hFD);
        repeat (8) @(posedge mclk);
        wr(UMCT_DATA_ADDR, 8'h55);
        wr(UMCT_DATA_ADDR, 8'hAA);
        remote.get_frame(8, 1, 1, d, p, sok, len);
        check("busy write ignored", d, 8'h55);
        wait_tx(n);
        count_low(100, lows);
        check("idle after frame", lows, 8'h00);
        wr(UMCT_DATA_ADDR, 8'h00);
        repeat (80) @(posedge mclk);
        cnt = tx_n;
        wr(UMCT_MODE_ADDR, 8'hBD);
        repeat (3) @(posedge mclk);
        count_low(100, lows);
        check("tx disabled line", lows, 8'h00);
        check("tx disabled done", 8'(tx_n - cnt), 8'h00);
        wr(UMCT_MODE_ADDR, 8'hFD);
        repeat (8) @(posedge mclk);
        wr(UMCT_DATA_ADDR, 8'h55);
        remote.get_frame(8, 1, 1, d, p, sok, len);
        check("tx after re-enable", d, 8'h55);
        wait_tx(n);
        remote.send_frame(8'h57, 8, 1, 1'b0);
        repeat (4) @(posedge mclk);
        rdchk("bad even parity", UMCT_ERR_ADDR, 8'h04);
        remote.send_frame(8'hA5, 8, 1, 1'b0);
        repeat (4) @(posedge mclk);
        rdchk("overrun keeps data", UMCT_DATA_ADDR, 8'h57);
        wr(UMCT_MODE_ADDR, 8'hDD);
        rdchk("error after rx off", UMCT_ERR_ADDR, 8'h00);
        wr(UMCT_MODE_ADDR, 8'h9D);
        wr(UMCT_MODE_ADDR, 8'h1D);
        rdchk("buffer after power off", UMCT_DATA_ADDR, 8'h00);
        wr(UMCT_LATCH_ADDR, 8'h00);
        repeat (2) @(posedge mclk);
        check("port pin", {7'h00, pin}, 8'h00);
        cnt = rx_n;
        remote.send_frame(8'h00, 8, 0, 1'b0);
        check("rx while off", 8'(rx_n - cnt), 8'h00);
        resetn = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        resetn = 1'b1;
        check("oe reset again", {7'h00, oe}, 8'h00);
        rdchk("mode reset", UMCT_MODE_ADDR, UMCT_MODE_RESET);
        rdchk("baud reset", UMCT_BAUD_ADDR, UMCT_BAUD_RESET);
        rdchk("error reset", UMCT_ERR_ADDR, UMCT_ERR_RESET);
        rdchk("dir reset", UMCT_DIR_ADDR, UMCT_DIR_RESET);
        rdchk("latch reset", UMCT_LATCH_ADDR, UMCT_LATCH_RESET);
        wr(16'hFF00, 8'hA5);
        rdchk("unmapped", 16'hFF00, 8'h00);
        wr(UMCT_BAUD_ADDR, 8'h08);
        wr(UMCT_MODE_ADDR, 8'h85);
        wr(UMCT_MODE_ADDR, 8'hC5);
        repeat (8) @(posedge mclk);
        wr(UMCT_DATA_ADDR, 8'hFF);
        count_low(300, lows);
        check("timer base start", {7'h00, (lows > 8'h3C && lows <= 8'h40)}, 8'h01);
        wr(UMCT_MODE_ADDR, 8'h85);
        wr(UMCT_BAUD_ADDR, 8'h88);
        wr(UMCT_MODE_ADDR, 8'hC5);
        repeat (8) @(posedge mclk);
        wr(UMCT_DATA_ADDR, 8'hFF);
        count_low(200, lows);
        check("div8 base start", {7'h00, (lows > 8'h78 && lows <= 8'h80)}, 8'h01);
        tally_and_finish();
    end
endmodule // umct_top_bench
`default_nettype wire
